// ===== hw/frx_regs.sv
/*
  receiver correction, preamble detector and timeout register bank behind
  an AXI4-Lite slave, with timeout counters, restart delay and interrupt.
  assumes event inputs and bit_tick come from logic on core_clk.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
// Behaviour
// - the 16-bit signed correction lives in a high and a low byte, and a host write replaces the addressed byte.
// - the error estimate is a signed count of synthesizer frequency steps.
// - bit 7 of the preamble register enables the detector, on by default, overridden in agc phase.
// - bits 6-5 choose one, two or three preamble bytes before the preamble interrupt; 11 reserved.
// - bits 4-0, default ten, give the tolerated chip errors, four chips per bit.
// - rssi timeout fires after value*16 bit periods in receive without rssi event; zero disables.
// - preamble timeout fires after value*16 bit periods in receive without preamble; zero disables.
// - sync timeout fires after value*16 bit periods in receive without sync match; zero disables.
// - an automatic restart is launched only after value*4 extra bit periods.
// - writing one to bit 3 of the oscillator register starts rc calibration in standby; reads 0.
// - bits 2-0 of the oscillator register, default 111, select the clock output source or off.
// - writing one to the correction clear bit in receive mode zeroes the correction; reads 0.
`timescale 1ns/1ps
module frx_regs
  import frx_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_mode,
  input wire logic standby_mode,
  input wire logic agc_phase,
  input wire logic agc_preamble_enable,
  input wire logic bit_tick,
  input wire logic rssi_event,
  input wire logic preamble_byte_ok,
  input wire logic sync_match_event,
  input wire logic restart_request,
  input wire logic afc_load,
  input wire logic [15:0] afc_value_in,
  input wire logic fei_update,
  input wire logic [15:0] fei_value_in,
  input wire logic rc_clk_pin,
  output logic [15:0] freq_correction_value,
  output logic preamble_detect_enable,
  output logic [1:0] preamble_detect_length,
  output logic [4:0] preamble_chip_error_tolerance,
  output logic rc_calibration_trigger,
  output logic restart_launch,
  output logic clock_out,
  output logic rc_osc_enable,
  output logic irq
);
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] freq_error_estimate;
  logic [7:0] ferr_low_frozen;
  logic [7:0] pre_cfg;
  logic [7:0] to_value [3];
  logic [7:0] restart_extra_delay;
  logic [2:0] clock_output_select;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic rx_prev;
  logic [1:0] pre_bytes;
  logic pre_found_done;
  logic [TIMEOUT_CNT_W-1:0] to_cnt [3];
  logic [2:0] to_run;
  logic [2:0] to_fire;
  logic [RESTART_CNT_W-1:0] rst_cnt;
  frx_restart_type rst_state;
  frx_restart_type next_rst_state;

  // bus decode
  wire logic [7:0] wr_idx = aw_addr[9:2];
  wire logic [7:0] rd_idx = s_axi_araddr[9:2];
  wire logic wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic wr_lane = wr_go && w_strb[0];
  wire logic [7:0] wr_byte = w_data[7:0];
  wire logic rd_go = s_axi_arvalid && s_axi_arready;
  wire logic wr_hit = (wr_idx >= IDX_CORR_CTRL && wr_idx <= IDX_OSC) ||
                      wr_idx == IDX_IRQ_STATUS || wr_idx == IDX_IRQ_MASK;
  wire logic rd_hit = (rd_idx >= IDX_CORR_CTRL && rd_idx <= IDX_OSC) ||
                      rd_idx == IDX_IRQ_STATUS || rd_idx == IDX_IRQ_MASK;
  wire logic wr_corr_ctrl = wr_lane && wr_idx == IDX_CORR_CTRL;
  wire logic wr_osc = wr_lane && wr_idx == IDX_OSC;
  wire logic corr_clear = wr_corr_ctrl && wr_byte[POS_CORR_CLEAR] && rx_mode;
  wire logic rc_cal_go = wr_osc && wr_byte[POS_RC_CAL] && standby_mode;
  wire logic rd_status = rd_go && rd_idx == IDX_IRQ_STATUS;
  wire logic rd_ferr_high = rd_go && rd_idx == IDX_FERR_HIGH;

  // read mux; trigger and clear bits always read as zero
  wire logic [7:0] rd_byte =
    (rd_idx == IDX_CORR_HIGH) ? freq_correction_value[15:8] :
    (rd_idx == IDX_CORR_LOW) ? freq_correction_value[7:0] :
    (rd_idx == IDX_FERR_HIGH) ? freq_error_estimate[15:8] :
    (rd_idx == IDX_FERR_LOW) ? ferr_low_frozen :
    (rd_idx == IDX_PRE_DET) ? pre_cfg :
    (rd_idx == IDX_TO_RSSI) ? to_value[0] :
    (rd_idx == IDX_TO_PRE) ? to_value[1] :
    (rd_idx == IDX_TO_SYNC) ? to_value[2] :
    (rd_idx == IDX_RESTART) ? restart_extra_delay :
    (rd_idx == IDX_OSC) ? {5'h00, clock_output_select} :
    (rd_idx == IDX_IRQ_STATUS) ? {3'h0, irq_status} :
    (rd_idx == IDX_IRQ_MASK) ? {3'h0, irq_mask} : 8'h00;

  // receive entry and exit
  wire logic rx_enter = rx_mode && !rx_prev;
  wire logic [1:0] pre_len_code = pre_cfg[POS_PRE_LEN_LO+1:POS_PRE_LEN_LO];
  wire logic [1:0] pre_need = (pre_len_code == 2'h3) ? 2'h2 : pre_len_code;
  wire logic pre_on = agc_phase ? agc_preamble_enable : pre_cfg[POS_PRE_ENABLE];
  wire logic pre_found = rx_mode && pre_on && preamble_byte_ok && !pre_found_done &&
                         pre_bytes == pre_need;
  wire logic [2:0] to_stop = {sync_match_event, pre_found, rssi_event};
  wire logic restart_done = rst_state == RST_LAUNCH;
  wire logic [IRQ_BITS-1:0] irq_set = {restart_done, pre_found, to_fire};
  wire logic [IRQ_BITS-1:0] next_irq_status = (rd_status ? '0 : irq_status) | irq_set;

  // axi handshakes: address and data taken in either order, one write at a time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // correction value: host write wins over the loop, clear wins over both
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_correction_value <= {RST_CORR, RST_CORR};
    end else if (corr_clear) begin
      freq_correction_value <= 16'h0000;
    end else if (wr_lane && wr_idx == IDX_CORR_HIGH) begin
      freq_correction_value[15:8] <= wr_byte;
    end else if (wr_lane && wr_idx == IDX_CORR_LOW) begin
      freq_correction_value[7:0] <= wr_byte;
    end else if (afc_load) begin
      freq_correction_value <= afc_value_in;
    end
  end

  // error estimate in synthesizer steps; low byte frozen by the high-byte read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_error_estimate <= 16'h0000;
      ferr_low_frozen <= 8'h00;
    end else begin
      if (fei_update) begin
        freq_error_estimate <= fei_value_in;
      end else if (wr_lane && wr_idx == IDX_FERR_HIGH) begin
        freq_error_estimate[15:8] <= wr_byte;
      end else if (wr_lane && wr_idx == IDX_FERR_LOW) begin
        freq_error_estimate[7:0] <= wr_byte;
      end
      if (rd_ferr_high) begin
        ferr_low_frozen <= freq_error_estimate[7:0];
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cfg <= RST_PRE_DET;
      restart_extra_delay <= RST_TIMEOUT;
      clock_output_select <= RST_OSC_SEL[2:0];
      irq_mask <= RST_IRQ;
    end else if (wr_lane) begin
      if (wr_idx == IDX_PRE_DET) pre_cfg <= wr_byte;
      if (wr_idx == IDX_RESTART) restart_extra_delay <= wr_byte;
      if (wr_idx == IDX_OSC) clock_output_select <= wr_byte[2:0];
      if (wr_idx == IDX_IRQ_MASK) irq_mask <= wr_byte[IRQ_BITS-1:0];
    end
  end

  // sticky status: a read clears, an event in the same cycle still sets
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // detector outputs; the agc phase supersedes the enable bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preamble_detect_enable <= 1'b0;
      preamble_detect_length <= 2'h0;
      preamble_chip_error_tolerance <= 5'h00;
      rc_calibration_trigger <= 1'b0;
      rx_prev <= 1'b0;
      pre_bytes <= 2'h0;
      pre_found_done <= 1'b0;
    end else begin
      preamble_detect_enable <= pre_on;
      preamble_detect_length <= pre_len_code;
      preamble_chip_error_tolerance <= pre_cfg[4:0];
      rc_calibration_trigger <= rc_cal_go;
      rx_prev <= rx_mode;
      if (rx_enter || !rx_mode || !pre_on) begin
        pre_bytes <= 2'h0;
        pre_found_done <= 1'b0;
      end else if (pre_found) begin
        pre_found_done <= 1'b1;
      end else if (preamble_byte_ok && !pre_found_done) begin
        pre_bytes <= pre_bytes + 2'h1;
      end
    end
  end

  // three receive timeouts counted in bit periods
  for (genvar ch = 0; ch < 3; ch++) begin : g_timeout
    wire logic [TIMEOUT_CNT_W-1:0] limit =
      TIMEOUT_CNT_W'(to_value[ch]) * TIMEOUT_CNT_W'(TIMEOUT_BITS_PER_UNIT);
    wire logic wr_this = wr_lane && wr_idx == IDX_TO_RSSI + 8'(ch);
    assign to_fire[ch] = to_run[ch] && bit_tick && (to_cnt[ch] + 1'b1 == limit);
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        to_value[ch] <= RST_TIMEOUT;
        to_cnt[ch] <= '0;
        to_run[ch] <= 1'b0;
      end else begin
        if (wr_this) to_value[ch] <= wr_byte;
        if (rx_enter) begin
          to_cnt[ch] <= '0;
          to_run[ch] <= to_value[ch] != 8'h00;
        end else if (!rx_mode || to_stop[ch] || to_fire[ch]) begin
          to_run[ch] <= 1'b0;
        end else if (to_run[ch] && bit_tick) begin
          to_cnt[ch] <= to_cnt[ch] + 1'b1;
        end
      end
    end
  end

  // restart delay; a zero delay launches two cycles after the request
  always_comb begin
    next_rst_state = rst_state;
    unique case (rst_state)
      RST_IDLE: if (restart_request) next_rst_state = RST_WAIT;
      RST_WAIT: if (rst_cnt == '0) next_rst_state = RST_LAUNCH;
      RST_LAUNCH: next_rst_state = RST_IDLE;
      default: next_rst_state = RST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_state <= RST_IDLE;
      rst_cnt <= '0;
      restart_launch <= 1'b0;
    end else begin
      rst_state <= next_rst_state;
      restart_launch <= next_rst_state == RST_LAUNCH;
      if (rst_state == RST_IDLE && restart_request) begin
        rst_cnt <= RESTART_CNT_W'(restart_extra_delay) *
                   RESTART_CNT_W'(RESTART_BITS_PER_UNIT);
      end else if (rst_state == RST_WAIT && bit_tick && rst_cnt != '0) begin
        rst_cnt <= rst_cnt - 1'b1;
      end
    end
  end

  frx_clock_output_select u_clock_output_select (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clock_output_select(clock_output_select),
    .rc_clk_pin(rc_clk_pin),
    .clock_out(clock_out),
    .rc_osc_enable(rc_osc_enable)
  );

  // checks
  logic rd_was_ctrl;
  logic rd_was_osc;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_was_ctrl <= 1'b0;
      rd_was_osc <= 1'b0;
    end else if (rd_go) begin
      rd_was_ctrl <= rd_idx == IDX_CORR_CTRL;
      rd_was_osc <= rd_idx == IDX_OSC;
    end
  end

  clear_reads_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid && rd_was_ctrl |-> !s_axi_rdata[POS_CORR_CLEAR])
    else $error("correction clear bit read back as one");

  cal_reads_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid && rd_was_osc |-> !s_axi_rdata[POS_RC_CAL])
    else $error("calibration trigger bit read back as one");

  cal_in_standby_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rc_calibration_trigger |-> $past(standby_mode) && $past(wr_osc))
    else $error("calibration started outside standby");

  clear_zeroes_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    corr_clear |=> freq_correction_value == 16'h0000)
    else $error("correction not cleared");

  timeout_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    to_value[2] == 8'h00 && rx_enter |=> !to_run[2])
    else $error("disabled sync timeout armed");

  timeout_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    to_fire[1] |-> to_cnt[1] == TIMEOUT_CNT_W'(to_value[1]) * 12'd16 - 12'd1)
    else $error("preamble timeout fired at wrong count");

  sync_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sync_match_event && !rx_enter |=> !to_run[2])
    else $error("sync timeout kept running after match");

  status_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    to_fire[0] |=> irq_status[IRQ_RSSI_TO])
    else $error("timeout event lost");

  restart_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_state == RST_IDLE && restart_request && restart_extra_delay == 8'h00
    |-> ##2 restart_launch)
    else $error("zero restart delay not honoured");

  ferr_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_ferr_high |=> ferr_low_frozen == $past(freq_error_estimate[7:0]))
    else $error("error low byte not frozen by high read");
endmodule : frx_regs

// ===== hw/frx_pkg.sv
/*
  package for the receiver correction/timeout register bank: register
  indices, field positions, reset values and derived counts.
  assumes a 32-bit AXI4-Lite bus where each 8-bit register sits in the
  low byte of an aligned word at byte address 4 * index.
*/
package frx_pkg;
  // register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_CORR_CTRL = 8'h1A;
  localparam logic [7:0] IDX_CORR_HIGH = 8'h1B;
  localparam logic [7:0] IDX_CORR_LOW = 8'h1C;
  localparam logic [7:0] IDX_FERR_HIGH = 8'h1D;
  localparam logic [7:0] IDX_FERR_LOW = 8'h1E;
  localparam logic [7:0] IDX_PRE_DET = 8'h1F;
  localparam logic [7:0] IDX_TO_RSSI = 8'h20;
  localparam logic [7:0] IDX_TO_PRE = 8'h21;
  localparam logic [7:0] IDX_TO_SYNC = 8'h22;
  localparam logic [7:0] IDX_RESTART = 8'h23;
  localparam logic [7:0] IDX_OSC = 8'h24;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;

  // reset values
  localparam logic [7:0] RST_CORR = 8'h00;
  localparam logic [7:0] RST_PRE_DET = 8'hAA;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_OSC_SEL = 8'h07;
  localparam logic [4:0] RST_IRQ = 5'h00;

  // field positions
  localparam int POS_CORR_CLEAR = 1;
  localparam int POS_PRE_ENABLE = 7;
  localparam int POS_PRE_LEN_LO = 5;
  localparam int POS_RC_CAL = 3;

  // interrupt status bits
  localparam int IRQ_BITS = 5;
  localparam int IRQ_RSSI_TO = 0;
  localparam int IRQ_PRE_TO = 1;
  localparam int IRQ_SYNC_TO = 2;
  localparam int IRQ_PRE_FOUND = 3;
  localparam int IRQ_RESTART = 4;

  // timing in bit periods
  localparam int TIMEOUT_BITS_PER_UNIT = 16;
  localparam int RESTART_BITS_PER_UNIT = 4;
  localparam int TIMEOUT_CNT_W = 12;
  localparam int RESTART_CNT_W = 10;

  // clock output select codes
  localparam logic [2:0] CLOCK_OUTPUT_SELECT_RC = 3'h6;
  localparam logic [2:0] CLOCK_OUTPUT_SELECT_OFF = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_WAIT = 2'b01,
    RST_LAUNCH = 2'b11
  } frx_restart_type;
endpackage : frx_pkg

// ===== hw/frx_clock_output_select.sv
/*
  clock output generator: divided crystal reference or the resynchronised
  rc oscillator, or held low when off.
  assumes core_clk runs at twice the crystal frequency, so a free counter
  bit k gives the crystal divided by 2**k; rc_clk_pin is asynchronous.
*/
`timescale 1ns/1ps
module frx_clock_output_select
  import frx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] clock_output_select,
  input wire logic rc_clk_pin,
  output logic clock_out,
  output logic rc_osc_enable
);
  logic [5:0] div_cnt;
  logic rc_sync1;
  logic rc_sync2;
  wire logic div_bit = (clock_output_select <= 3'h5) ? div_cnt[clock_output_select] : 1'b0;
  wire logic next_clock_out = (clock_output_select == CLOCK_OUTPUT_SELECT_RC) ? rc_sync2 : div_bit;

  // rc source is asynchronous: two flops before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 6'h00;
      rc_sync1 <= 1'b0;
      rc_sync2 <= 1'b0;
      clock_out <= 1'b0;
      rc_osc_enable <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 6'h01;
      rc_sync1 <= rc_clk_pin;
      rc_sync2 <= rc_sync1;
      clock_out <= next_clock_out;
      rc_osc_enable <= (clock_output_select == CLOCK_OUTPUT_SELECT_RC);
    end
  end
endmodule : frx_clock_output_select

// ===== verification/frx_host_model.sv
/*
  host model: an axi4-lite master issuing one register write or read at a time.
  assumes the slave shares core_clk and answers with its own ready and valid.
*/
`timescale 1ns/1ps
module frx_host_model (
  input wire logic core_clk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
  end

  // handshakes are looked at on the falling edge so the rising edge never races the slave
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp,
                           output bit ok);
    bit a;
    bit w;
    bit b;
    ok = 1'h0;
    @(posedge core_clk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge core_clk);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (a) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) begin
        s_axi_bready <= 1'h0;
        ok = 1'h1;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp,
                          output bit ok);
    bit a;
    bit r;
    ok = 1'h0;
    @(posedge core_clk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge core_clk);
      a = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (a) s_axi_arvalid <= 1'h0;
      if (r) begin
        s_axi_rready <= 1'h0;
        ok = 1'h1;
      end
    end
  endtask : axi_read
endmodule : frx_host_model

// ===== verification/fsk_rx_afc_timeout_control_tb_top.sv
/*
  self-checking bench: register table, timeouts, restart delay, calibration and irq.
  assumes the host model drives the axi4-lite port; bit period is two clock cycles.
*/
`timescale 1ns/1ps
module fsk_rx_afc_timeout_control_tb_top
  import frx_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
  } frx_row_type;

  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, preamble_detect_length;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rx_mode = 1'h0, standby_mode = 1'h0, agc_phase = 1'h0, agc_preamble_enable = 1'h0;
  logic bit_tick = 1'h0, rssi_event = 1'h0, preamble_byte_ok = 1'h0, sync_match_event = 1'h0;
  logic restart_request = 1'h0, afc_load = 1'h0, fei_update = 1'h0, rc_clk_pin = 1'h0;
  logic [15:0] afc_value_in = 16'h0000, fei_value_in = 16'h0000, freq_correction_value;
  logic preamble_detect_enable, rc_calibration_trigger, restart_launch, clock_out, rc_osc_enable;
  logic irq, prev_clk;
  logic cal_seen = 1'h0;
  logic [4:0] preamble_chip_error_tolerance;
  int num_errors = 0, check_count = 0, n;
  // reset reads first, then write and read back; 0x30 is unmapped
  frx_row_type rows [17] = '{'{1'h0, 8'h1B, 8'h00, 8'h00, RESP_OKAY},
    '{1'h0, 8'h1C, 8'h00, 8'h00, RESP_OKAY}, '{1'h0, 8'h1F, 8'h00, 8'hAA, RESP_OKAY},
    '{1'h0, 8'h20, 8'h00, 8'h00, RESP_OKAY}, '{1'h0, 8'h23, 8'h00, 8'h00, RESP_OKAY},
    '{1'h0, 8'h24, 8'h00, 8'h07, RESP_OKAY}, '{1'h0, 8'h41, 8'h00, 8'h00, RESP_OKAY},
    '{1'h1, 8'h1B, 8'h80, 8'h80, RESP_OKAY}, '{1'h1, 8'h1C, 8'h7F, 8'h7F, RESP_OKAY},
    '{1'h1, 8'h1F, 8'h5F, 8'h5F, RESP_OKAY}, '{1'h1, 8'h20, 8'h01, 8'h01, RESP_OKAY},
    '{1'h1, 8'h21, 8'h02, 8'h02, RESP_OKAY}, '{1'h1, 8'h22, 8'h00, 8'h00, RESP_OKAY},
    '{1'h1, 8'h23, 8'h02, 8'h02, RESP_OKAY}, '{1'h1, 8'h24, 8'h0E, 8'h06, RESP_OKAY},
    '{1'h1, 8'h1A, 8'h02, 8'h00, RESP_OKAY}, '{1'h1, 8'h30, 8'h55, 8'h00, RESP_SLVERR}};

  always #5 core_clk = ~core_clk;
  always #37 rc_clk_pin = ~rc_clk_pin;
  always @(posedge core_clk) bit_tick <= ~bit_tick;
  always @(posedge core_clk) if (rc_calibration_trigger) cal_seen <= 1'h1;

  frx_host_model i_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  frx_regs #(.ADDR_W(12)) i_dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_mode, .standby_mode, .agc_phase, .agc_preamble_enable,
    .bit_tick, .rssi_event, .preamble_byte_ok, .sync_match_event, .restart_request, .afc_load,
    .afc_value_in, .fei_update, .fei_value_in, .rc_clk_pin, .freq_correction_value,
    .preamble_detect_enable, .preamble_detect_length, .preamble_chip_error_tolerance,
    .rc_calibration_trigger, .restart_launch, .clock_out, .rc_osc_enable, .irq);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask : check

  task automatic results();
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit ok;
    i_host.axi_write(idx, d, r, ok);
    check(ok, 1'h1);
    check(r, er);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    i_host.axi_read(idx, d, r, ok);
    check(ok, 1'h1);
    check(d, {24'h000000, exp});
    check(r, er);
  endtask : rd

  // pulses two clocks apart, each on its own edge
  task automatic preamble_bytes(input int k);
    repeat (k) begin
      @(posedge core_clk);
      preamble_byte_ok <= 1'h1;
      @(posedge core_clk);
      preamble_byte_ok <= 1'h0;
    end
  endtask : preamble_bytes

  // a hang ends the run through the same report
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].idx, rows[i].wd, rows[i].resp);
      rd(rows[i].idx, rows[i].rd, rows[i].resp);
    end
    @(negedge core_clk);
    check(freq_correction_value, 32'h807F);
    check({preamble_detect_enable, preamble_detect_length, preamble_chip_error_tolerance}, 8'h5F);
    check({rc_osc_enable, cal_seen}, 2'h2);
    @(posedge core_clk);
    agc_phase <= 1'h1;
    agc_preamble_enable <= 1'h1;
    repeat (3) @(negedge core_clk);
    check(preamble_detect_enable, 1'h1);
    @(posedge core_clk);
    fei_value_in <= 16'h1234;
    fei_update <= 1'h1;
    afc_value_in <= 16'hA5C3;
    afc_load <= 1'h1;
    @(posedge core_clk);
    fei_update <= 1'h0;
    afc_load <= 1'h0;
    rd(8'h1D, 8'h12, RESP_OKAY);
    fei_value_in <= 16'h5678;
    fei_update <= 1'h1;
    @(posedge core_clk);
    fei_update <= 1'h0;
    rd(8'h1E, 8'h34, RESP_OKAY);
    check(freq_correction_value, 32'hA5C3);
    wr(8'h1B, 8'h11, RESP_OKAY);
    @(negedge core_clk);
    check(freq_correction_value, 32'h11C3);
    wr(8'h41, 8'h1F, RESP_OKAY);
    @(posedge core_clk);
    rx_mode <= 1'h1;
    repeat (20) @(posedge core_clk);
    rd(8'h40, 8'h00, RESP_OKAY);
    for (n = 0; n < 40 && irq !== 1'h1; n++) @(negedge core_clk);
    check(irq, 1'h1);
    rd(8'h40, 8'h01, RESP_OKAY);
    preamble_bytes(2);
    rd(8'h40, 8'h00, RESP_OKAY);
    check(irq, 1'h0);
    preamble_bytes(1);
    rd(8'h40, 8'h08, RESP_OKAY);
    repeat (40) @(posedge core_clk);
    rd(8'h40, 8'h00, RESP_OKAY);
    wr(8'h41, 8'h00, RESP_OKAY);
    wr(8'h22, 8'h01, RESP_OKAY);
    rx_mode <= 1'h0;
    @(posedge core_clk);
    rx_mode <= 1'h1;
    @(posedge core_clk);
    {rssi_event, sync_match_event} <= 2'h3;
    @(posedge core_clk);
    {rssi_event, sync_match_event} <= 2'h0;
    repeat (80) @(negedge core_clk);
    check(irq, 1'h0);
    rd(8'h40, 8'h02, RESP_OKAY);
    wr(8'h1A, 8'h02, RESP_OKAY);
    @(negedge core_clk);
    check(freq_correction_value, 32'h0000);
    @(posedge core_clk);
    rx_mode <= 1'h0;
    restart_request <= 1'h1;
    @(posedge core_clk);
    restart_request <= 1'h0;
    for (n = 0; n < 100 && restart_launch !== 1'h1; n++) @(negedge core_clk);
    check(n inside {[13:19]}, 1'h1);
    wr(8'h23, 8'h00, RESP_OKAY);
    restart_request <= 1'h1;
    @(posedge core_clk);
    restart_request <= 1'h0;
    repeat (2) @(negedge core_clk);
    check(restart_launch, 1'h1);
    @(posedge core_clk);
    standby_mode <= 1'h1;
    wr(8'h24, 8'h0F, RESP_OKAY);
    repeat (2) @(negedge core_clk);
    check({cal_seen, clock_out}, 2'h2);
    rd(8'h24, 8'h07, RESP_OKAY);
    wr(8'h24, 8'h00, RESP_OKAY);
    @(negedge core_clk);
    prev_clk = clock_out;
    @(negedge core_clk);
    check(clock_out, !prev_clk);
    results();
  end
endmodule : fsk_rx_afc_timeout_control_tb_top
